// ===== src/queue_tx_pkg.sv
`default_nettype none
package queue_tx_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int          ADDR_W                = 9;
    localparam logic [8:0]  TRANSMIT_CONTROL_OFF  = 9'h170;
    localparam logic [8:0]  TRANSMIT_STATUS_OFF   = 9'h172;
    localparam logic [15:0] TRANSMIT_CONTROL_RST  = 16'h0000;
    localparam logic [15:0] TRANSMIT_STATUS_RST   = 16'h0000;
    localparam logic [15:0] TRANSMIT_CONTROL_MASK = 16'h01ff;

    // Control field positions.
    localparam int CTL_ICMP_BIT  = 8;
    localparam int CTL_UDP_BIT   = 7;
    localparam int CTL_TCP_BIT   = 6;
    localparam int CTL_IP_BIT    = 5;
    localparam int CTL_FLUSH_BIT = 4;
    localparam int CTL_FC_BIT    = 3;
    localparam int CTL_PAD_BIT   = 2;
    localparam int CTL_CRC_BIT   = 1;
    localparam int CTL_RUN_BIT   = 0;

    // Status field positions.
    localparam int STS_LATE_BIT = 13;
    localparam int STS_MAX_BIT  = 12;
    localparam int STS_FID_LSB  = 0;
    localparam int FID_W        = 6;

    // ************************************************************
    // Frame constants
    // ************************************************************
    localparam int          MIN_FRAME_BYTES = 64;
    localparam int          CRC_BYTES       = 4;
    localparam int          PAD_TARGET      = MIN_FRAME_BYTES - CRC_BYTES;
    localparam int          FIFO_DEPTH      = 8;
    localparam logic [31:0] CRC_INIT        = 32'hffffffff;
    localparam logic [31:0] CRC_POLY        = 32'hedb88320;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [7:0]       data;
        logic             last;
        logic [FID_W-1:0] fid;
        logic             is_ip;
        logic             is_icmp;
        logic             is_udp;
        logic             is_tcp;
        logic             fragmented;
    } tx_word_t;

    typedef struct packed {
        logic icmp;
        logic udp;
        logic tcp;
        logic ip;
    } cks_insert_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } tx_byte_t;

endpackage
`default_nettype wire

// ===== src/tx_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             clear,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("tx_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;

    // Full when the pointers differ only in the wrap bit.
    assign in_ready  = !clear && !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid = !clear && (wr_ptr != rd_ptr);
    assign out_data  = mem[rd_ptr[AW-1:0]];

    // Pointers; a clear drops every stored word at once.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (in_valid && in_ready) wr_ptr <= wr_ptr + 1'b1;
            if (out_valid && out_ready) rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // Storage is written only on an accepted word.
    always_ff @(posedge clk) begin
        if (in_valid && in_ready) mem[wr_ptr[AW-1:0]] <= in_data;
    end
endmodule
`default_nettype wire

// ===== src/queue_tx_control_status.sv
`timescale 1ns/1ps
`default_nettype none
module queue_tx_control_status
    import queue_tx_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [1:0]        reg_be,
    input  wire logic [15:0]       reg_wdata,
    output logic      [15:0]       reg_rdata,
    input  wire tx_word_t          queue_word,
    input  wire logic              queue_valid,
    output logic                   queue_ready,
    output tx_byte_t               mac_byte,
    output logic                   mac_valid,
    input  wire logic              mac_ready,
    output cks_insert_t            cks_insert,
    output logic                   frame_start,
    input  wire logic              late_collision,
    input  wire logic              max_collision,
    input  wire logic              full_duplex,
    input  wire logic              rx_threshold,
    output logic                   pause_req,
    output logic                   backpressure
);

    initial begin
        if (DEPTH < 2) $error("queue depth too small");
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic [15:0] transmit_control;
    logic [15:0] transmit_status;
    logic        icmp_checksum_gen_en;
    logic        udp_checksum_gen_en;
    logic        tcp_checksum_gen_en;
    logic        ip_header_checksum_gen_en;
    logic        transmit_queue_flush;
    logic        transmit_flow_control_en;
    logic        transmit_padding_en;
    logic        transmit_crc_append_en;
    logic        transmit_run_en;

    assign icmp_checksum_gen_en      = transmit_control[CTL_ICMP_BIT];
    assign udp_checksum_gen_en       = transmit_control[CTL_UDP_BIT];
    assign tcp_checksum_gen_en       = transmit_control[CTL_TCP_BIT];
    assign ip_header_checksum_gen_en = transmit_control[CTL_IP_BIT];
    assign transmit_queue_flush      = transmit_control[CTL_FLUSH_BIT];
    assign transmit_flow_control_en  = transmit_control[CTL_FC_BIT];
    assign transmit_padding_en       = transmit_control[CTL_PAD_BIT];
    assign transmit_crc_append_en    = transmit_control[CTL_CRC_BIT];
    assign transmit_run_en           = transmit_control[CTL_RUN_BIT];

    // Control writes honour byte lanes; reserved bits never store.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            transmit_control <= TRANSMIT_CONTROL_RST;
        end else if (reg_wr && reg_addr == TRANSMIT_CONTROL_OFF) begin
            if (reg_be[0]) transmit_control[7:0] <= reg_wdata[7:0];
            if (reg_be[1]) transmit_control[15:8] <= reg_wdata[15:8] & TRANSMIT_CONTROL_MASK[15:8];
        end
    end

    // Read data is registered; status and unmapped addresses ignore writes.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                TRANSMIT_CONTROL_OFF: reg_rdata <= transmit_control & TRANSMIT_CONTROL_MASK;
                TRANSMIT_STATUS_OFF:  reg_rdata <= transmit_status;
                default:              reg_rdata <= 16'h0000;
            endcase
        end
    end

    // ************************************************************
    // Queue
    // ************************************************************
    tx_word_t f_word;
    logic     f_valid;
    logic     f_ready;

    tx_fifo #(
        .WIDTH ($bits(tx_word_t)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .clear     (transmit_queue_flush),
        .in_data   (queue_word),
        .in_valid  (queue_valid),
        .in_ready  (queue_ready),
        .out_data  (f_word),
        .out_valid (f_valid),
        .out_ready (f_ready)
    );

    // ************************************************************
    // Transmit engine
    // ************************************************************
    typedef enum logic [2:0] {ST_STOPPED, ST_IDLE, ST_DATA, ST_PAD, ST_CRC} tx_state_t;

    tx_state_t        state;
    logic [31:0]      crc;
    logic [10:0]      byte_cnt;
    logic [1:0]       crc_idx;
    logic             mode_pad;
    logic             mode_crc;
    logic [FID_W-1:0] cur_fid;
    logic             can_load;
    logic             start_ok;
    logic             end_hs;
    logic             short_now;

    // The output byte may be replaced once the MAC has taken the old one.
    assign can_load  = !mac_valid || mac_ready;
    // A new frame waits for the previous last byte, so the identifier stays valid.
    assign start_ok  = transmit_run_en && !transmit_queue_flush && f_valid && !mac_valid;
    assign f_ready   = (state == ST_DATA) && can_load;
    assign end_hs    = mac_valid && mac_byte.last && mac_ready;
    assign short_now = mode_pad && (byte_cnt + 11'd1 < 11'(PAD_TARGET));

    // Reflected CRC-32 over one byte.
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // State sequencing: stop requests take effect only between frames.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_STOPPED;
        end else if (transmit_queue_flush) begin
            state <= ST_STOPPED;
        end else begin
            unique case (state)
                ST_STOPPED: if (transmit_run_en) state <= ST_IDLE;
                ST_IDLE: begin
                    if (!transmit_run_en) state <= ST_STOPPED;
                    else if (start_ok) state <= ST_DATA;
                end
                ST_DATA: begin
                    if (can_load && f_valid && f_word.last) begin
                        if (short_now) state <= ST_PAD;
                        else if (mode_crc) state <= ST_CRC;
                        else state <= transmit_run_en ? ST_IDLE : ST_STOPPED;
                    end
                end
                ST_PAD: begin
                    if (can_load && byte_cnt + 11'd1 == 11'(PAD_TARGET)) begin
                        if (mode_crc) state <= ST_CRC;
                        else state <= transmit_run_en ? ST_IDLE : ST_STOPPED;
                    end
                end
                ST_CRC: begin
                    if (can_load && crc_idx == 2'd3) begin
                        state <= transmit_run_en ? ST_IDLE : ST_STOPPED;
                    end
                end
            endcase
        end
    end

    // Output byte register and running CRC and length.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mac_valid <= 1'b0;
            mac_byte  <= '0;
            crc       <= CRC_INIT;
            byte_cnt  <= '0;
            crc_idx   <= '0;
        end else if (transmit_queue_flush) begin
            mac_valid <= 1'b0;
            crc       <= CRC_INIT;
            byte_cnt  <= '0;
            crc_idx   <= '0;
        end else if (state == ST_IDLE && start_ok) begin
            crc      <= CRC_INIT;
            byte_cnt <= '0;
            crc_idx  <= '0;
        end else if (can_load) begin
            mac_valid <= 1'b0;
            if (state == ST_DATA && f_valid) begin
                mac_valid     <= 1'b1;
                mac_byte.data <= f_word.data;
                mac_byte.last <= f_word.last && !short_now && !mode_crc;
                crc           <= crc_byte(crc, f_word.data);
                byte_cnt      <= byte_cnt + 11'd1;
            end else if (state == ST_PAD) begin
                mac_valid     <= 1'b1;
                mac_byte.data <= 8'h00;
                mac_byte.last <= !mode_crc && (byte_cnt + 11'd1 == 11'(PAD_TARGET));
                crc           <= crc_byte(crc, 8'h00);
                byte_cnt      <= byte_cnt + 11'd1;
            end else if (state == ST_CRC) begin
                mac_valid     <= 1'b1;
                mac_byte.data <= ~crc[8*crc_idx +: 8];
                mac_byte.last <= (crc_idx == 2'd3);
                crc_idx       <= crc_idx + 2'd1;
            end
        end
    end

    // Per-frame modes and checksum insertion are fixed at the frame's first word.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_pad    <= 1'b0;
            mode_crc    <= 1'b0;
            cur_fid     <= '0;
            cks_insert  <= '0;
            frame_start <= 1'b0;
        end else begin
            frame_start <= 1'b0;
            if (state == ST_IDLE && start_ok) begin
                mode_pad        <= transmit_padding_en;
                mode_crc        <= transmit_crc_append_en;
                cur_fid         <= f_word.fid;
                frame_start     <= 1'b1;
                cks_insert.icmp <= icmp_checksum_gen_en && f_word.is_icmp && !f_word.fragmented;
                cks_insert.udp  <= udp_checksum_gen_en && f_word.is_udp && !f_word.fragmented;
                cks_insert.tcp  <= tcp_checksum_gen_en && f_word.is_tcp && !f_word.fragmented;
                cks_insert.ip   <= ip_header_checksum_gen_en && f_word.is_ip && !f_word.fragmented;
            end
        end
    end

    // ************************************************************
    // Status capture
    // ************************************************************
    logic pend_late;
    logic pend_max;

    // Collisions gather during the frame; a new frame starts them afresh.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend_late <= 1'b0;
            pend_max  <= 1'b0;
        end else if (end_hs) begin
            pend_late <= 1'b0;
            pend_max  <= 1'b0;
        end else begin
            // A pulse that meets the frame start belongs to the new frame, so the set wins.
            if (frame_start) begin
                pend_late <= 1'b0;
                pend_max  <= 1'b0;
            end
            if (late_collision) pend_late <= 1'b1;
            if (max_collision) pend_max <= 1'b1;
        end
    end

    // All fields change in one edge so a read never mixes two frames.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            transmit_status <= TRANSMIT_STATUS_RST;
        end else if (end_hs) begin
            transmit_status                             <= 16'h0000;
            transmit_status[STS_LATE_BIT]               <= pend_late || late_collision;
            transmit_status[STS_MAX_BIT]                <= pend_max || max_collision;
            transmit_status[STS_FID_LSB +: FID_W]       <= cur_fid;
        end
    end

    // ************************************************************
    // Flow control
    // ************************************************************
    logic thr_prev;

    // A pause is requested once per rise of the threshold, not per cycle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            thr_prev     <= 1'b0;
            pause_req    <= 1'b0;
            backpressure <= 1'b0;
        end else begin
            thr_prev     <= rx_threshold;
            pause_req    <= transmit_flow_control_en && full_duplex && rx_threshold && !thr_prev;
            backpressure <= transmit_flow_control_en && !full_duplex && rx_threshold;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [10:0] out_cnt;

    // Counts bytes the MAC accepted in the current frame.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) out_cnt <= '0;
        else if (end_hs) out_cnt <= '0;
        else if (mac_valid && mac_ready) out_cnt <= out_cnt + 11'd1;
    end

    property p_flush_empties;
        @(posedge clk) disable iff (!resetn)
        transmit_queue_flush |=> !f_valid && !mac_valid && state == ST_STOPPED;
    endproperty
    a_flush_empties: assert property (p_flush_empties) else $error("flush left data queued");

    property p_run_start;
        @(posedge clk) disable iff (!resetn)
        (state == ST_STOPPED) && transmit_run_en && !transmit_queue_flush |=> state == ST_IDLE;
    endproperty
    a_run_start: assert property (p_run_start) else $error("transmitter did not start");

    property p_finish_frame;
        @(posedge clk) disable iff (!resetn)
        (state == ST_DATA || state == ST_PAD || state == ST_CRC) && !transmit_queue_flush
            |=> state != ST_STOPPED || (mac_valid && mac_byte.last);
    endproperty
    a_finish_frame: assert property (p_finish_frame) else $error("frame cut short by stop");

    property p_pad_len;
        @(posedge clk) disable iff (!resetn)
        end_hs && mode_pad && mode_crc |-> out_cnt + 11'd1 >= 11'(MIN_FRAME_BYTES);
    endproperty
    a_pad_len: assert property (p_pad_len) else $error("padded frame too short");

    sequence s_crc_tail;
        state == ST_CRC && can_load && crc_idx == 2'd3 && !transmit_queue_flush;
    endsequence
    property p_crc_last;
        @(posedge clk) disable iff (!resetn)
        s_crc_tail |=> mac_valid && mac_byte.last && state != ST_CRC;
    endproperty
    a_crc_last: assert property (p_crc_last) else $error("crc not final field");

    property p_status_fid;
        @(posedge clk) disable iff (!resetn)
        end_hs |=> transmit_status[STS_FID_LSB +: FID_W] == $past(cur_fid)
            && transmit_status[11:6] == 6'h00;
    endproperty
    a_status_fid: assert property (p_status_fid) else $error("status id mismatch");

    property p_late_flag;
        @(posedge clk) disable iff (!resetn)
        late_collision && !end_hs |=> pend_late;
    endproperty
    a_late_flag: assert property (p_late_flag) else $error("late collision not held");

    property p_max_flag;
        @(posedge clk) disable iff (!resetn)
        end_hs && max_collision |=> transmit_status[STS_MAX_BIT];
    endproperty
    a_max_flag: assert property (p_max_flag) else $error("max collision flag lost");

    property p_late_now;
        @(posedge clk) disable iff (!resetn)
        end_hs && (late_collision || pend_late) |=> transmit_status[STS_LATE_BIT];
    endproperty
    a_late_now: assert property (p_late_now) else $error("late collision flag lost");

    property p_status_hold;
        @(posedge clk) disable iff (!resetn)
        !end_hs |=> $stable(transmit_status);
    endproperty
    a_status_hold: assert property (p_status_hold) else $error("status changed mid-frame");

    property p_pause;
        @(posedge clk) disable iff (!resetn)
        transmit_flow_control_en && full_duplex && $rose(rx_threshold) |=> pause_req ##1 !pause_req;
    endproperty
    a_pause: assert property (p_pause) else $error("pause frame not requested");

    property p_no_fc;
        @(posedge clk) disable iff (!resetn)
        !transmit_flow_control_en |=> !pause_req && !backpressure;
    endproperty
    a_no_fc: assert property (p_no_fc) else $error("flow control while disabled");

    property p_frag;
        @(posedge clk) disable iff (!resetn)
        state == ST_IDLE && start_ok && f_word.fragmented |=> cks_insert == '0;
    endproperty
    a_frag: assert property (p_frag) else $error("checksum on fragment");

    property p_rsv_read;
        @(posedge clk) disable iff (!resetn)
        reg_rd && reg_addr == TRANSMIT_CONTROL_OFF |=> reg_rdata[15:9] == 7'h00;
    endproperty
    a_rsv_read: assert property (p_rsv_read) else $error("reserved bits read nonzero");

endmodule
`default_nettype wire

// ===== test/host_queue_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_queue_model
    import queue_tx_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [7:0] len,
    input  wire tx_word_t   hdr,
    output tx_word_t        word,
    output logic            valid,
    input  wire logic       ready
);
    // Pushes one frame per go pulse and holds each word until it is taken.
    // A released bus shows inverted data so stale words cannot pass.
    initial begin
        word = '0;
        valid = 1'b0;
        forever begin
            @(posedge go);
            for (int i = 0; i < len; i++) begin
                @(negedge clk);
                word = hdr;
                word.data = 8'(i);
                word.last = (i == len - 1);
                valid = 1'b1;
                while (!ready) @(negedge clk);
                @(posedge clk);
            end
            @(negedge clk);
            valid = 1'b0;
            word = ~word;
        end
    end
endmodule
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import queue_tx_pkg::*;
;
    logic              clk, resetn, reg_wr, reg_rd, queue_valid, queue_ready, go;
    logic              mac_valid, mac_ready, frame_start, late_collision, max_collision;
    logic              full_duplex, rx_threshold, pause_req, backpressure;
    logic [ADDR_W-1:0] reg_addr;
    logic [1:0]        reg_be;
    logic [15:0]       reg_wdata, reg_rdata;
    logic [7:0]        len;
    tx_word_t          queue_word, hdr, h;
    tx_byte_t          mac_byte;
    cks_insert_t       cks_insert;
    int                n_errors, checked, nbytes, nlast, npause, nstart;
    logic [31:0]       fcs = 32'hffffffff;
    logic [31:0]       resid;

    queue_tx_control_status uut (.clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_be,
        .reg_wdata, .reg_rdata, .queue_word, .queue_valid, .queue_ready, .mac_byte,
        .mac_valid, .mac_ready, .cks_insert, .frame_start, .late_collision,
        .max_collision, .full_duplex, .rx_threshold, .pause_req, .backpressure);
    host_queue_model host (.clk, .go, .len, .hdr, .word(queue_word), .valid(queue_valid),
        .ready(queue_ready));

    // ********
    // Clock, far-side sink and watchdog
    // ********
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // The sink stalls every other cycle so held bytes are exercised.
    always @(negedge clk) mac_ready <= ~mac_ready;
    // Counts accepted bytes and pulses at the sampling edge.
    // A whole frame run through the CRC with its check field leaves a fixed residue.
    always @(posedge clk) begin
        if (frame_start) nstart++;
        if (mac_valid && mac_ready) begin
            nbytes++;
            fcs = crc8(fcs, mac_byte.data);
        end
        if (mac_valid && mac_ready && mac_byte.last) begin
            nlast = nbytes;
            resid = fcs;
            fcs = 32'hffffffff;
        end
        if (pause_req) npause++;
    end
    // Reflected CRC-32 step over one byte, as the Ethernet check field defines it.
    function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        return r;
    endfunction
    initial begin
        #100000;
        n_errors++;
        test_done;
    end

    task test_done;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input string s, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task wr(input logic [8:0] a, input logic [15:0] d);
        @(negedge clk); reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
        @(negedge clk); reg_wr = 1'b0;
    endtask
    task rd(input logic [8:0] a, input logic [15:0] e, input string s);
        @(negedge clk); reg_addr = a; reg_rd = 1'b1;
        @(negedge clk); reg_rd = 1'b0;
        chk(s, e, reg_rdata);
    endtask
    // Starts one frame in the host model and, when wait_end is set, waits a bounded time for its end.
    task send(input logic [7:0] n, input logic wait_end);
        @(negedge clk); nbytes = 0; nlast = 0; nstart = 0; len = n; hdr = h; go = 1'b1;
        @(negedge clk); go = 1'b0;
        for (int i = 0; i < 400 && wait_end && nlast == 0; i++) @(negedge clk);
    endtask

    // ********
    // Scenarios
    // ********
    task t_regs;
        rd(TRANSMIT_CONTROL_OFF, 16'h0000, "ctl reset");
        wr(TRANSMIT_CONTROL_OFF, 16'hffff);
        rd(TRANSMIT_CONTROL_OFF, 16'h01ff, "ctl");
        wr(TRANSMIT_CONTROL_OFF, 16'h0000);
        wr(TRANSMIT_STATUS_OFF, 16'hffff);
        rd(TRANSMIT_STATUS_OFF, 16'h0000, "sts");
        rd(9'h174, 16'h0000, "unmapped");
    endtask
    task t_pad;
        h = '0; h.fid = 6'h2a; h.is_ip = 1'b1; h.is_icmp = 1'b1;
        wr(TRANSMIT_CONTROL_OFF, 16'h0127);
        fork
            send(8'd3, 1'b1);
            begin
                repeat (10) @(negedge clk); late_collision = 1'b1; max_collision = 1'b1;
                @(negedge clk); late_collision = 1'b0; max_collision = 1'b0;
            end
        join
        chk("bytes", 16'd64, 16'(nlast));
        chk("fcs lo", 16'h20e3, resid[15:0]);
        chk("fcs hi", 16'hdebb, resid[31:16]);
        chk("starts", 16'd1, 16'(nstart));
        chk("cks", 16'h0009, 16'(cks_insert));
        rd(TRANSMIT_STATUS_OFF, 16'h302a, "sts");
    endtask
    task t_stop;
        h = '0; h.fid = 6'h15; h.is_udp = 1'b1; h.fragmented = 1'b1;
        wr(TRANSMIT_CONTROL_OFF, 16'h0083);
        send(8'd5, 1'b0);
        repeat (6) @(negedge clk);
        wr(TRANSMIT_CONTROL_OFF, 16'h0082);
        for (int i = 0; i < 100 && nlast == 0; i++) @(negedge clk);
        chk("bytes", 16'd9, 16'(nlast));
        chk("fcs lo", 16'h20e3, resid[15:0]);
        chk("cks", 16'h0000, 16'(cks_insert));
        rd(TRANSMIT_STATUS_OFF, 16'h0015, "sts");
    endtask
    task t_flush;
        send(8'd4, 1'b0);
        repeat (20) @(negedge clk);
        chk("stopped", 16'd0, 16'(nbytes));
        wr(TRANSMIT_CONTROL_OFF, 16'h0010);
        chk("ready", 16'd0, 16'(queue_ready));
        wr(TRANSMIT_CONTROL_OFF, 16'h0001);
        repeat (20) @(negedge clk);
        chk("flushed", 16'd0, 16'(nbytes));
    endtask
    task t_flow;
        npause = 0;
        wr(TRANSMIT_CONTROL_OFF, 16'h0008);
        full_duplex = 1'b1; rx_threshold = 1'b1;
        repeat (4) @(negedge clk);
        chk("pause", 16'd1, 16'(npause));
        full_duplex = 1'b0;
        repeat (3) @(negedge clk);
        chk("bp", 16'd1, 16'(backpressure));
        wr(TRANSMIT_CONTROL_OFF, 16'h0000);
        @(negedge clk);
        chk("bp off", 16'd0, 16'(backpressure));
    endtask

    initial begin
        {resetn, reg_wr, reg_rd, go, mac_ready, late_collision, max_collision} = '0;
        {full_duplex, rx_threshold, reg_addr, reg_wdata, len, hdr, h} = '0;
        reg_be = 2'b11;
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        t_regs;
        t_pad;
        t_stop;
        t_flush;
        t_flow;
        test_done;
    end
endmodule
`default_nettype wire
